// ---- bench/flic_checker.sv ----
// port assertions for the interrupt controller
`timescale 1ns/100ps
module flic_checker #(
  parameter ADR_W = 10
) (
  input wire             clk_i,
  input wire             rst_i,
  input wire             wb_cyc_i,
  input wire             wb_stb_i,
  input wire             wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0]       wb_sel_i,
  input wire [31:0]      wb_dat_i,
  input wire [31:0]      wb_dat_o,
  input wire             wb_ack_o,
  input wire             ext_irq_pin_zero_n_i,
  input wire             ext_irq_pin_one_n_i,
  input wire             vector_ack_i,
  input wire             irq_req_o,
  input wire [2:0]       irq_vec_o,
  input wire [1:0]       irq_lvl_o,
  input wire             power_down_o
);
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  a_ack_after_take: assert property (tk |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_bit_rsvd: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 10'h2DC |-> wb_dat_o[31:7] == 25'h0)
    else $error("reserved priority bit set");
  a_vector_in_range: assert property (irq_req_o |-> irq_vec_o < 3'h6)
    else $error("vector out of range");
  // a new request after a take must sit strictly above the taken level
  a_ack_drops_req: assert property (
    irq_req_o && vector_ack_i |=> !irq_req_o || irq_lvl_o > $past(irq_lvl_o))
    else $error("request kept after take");
  a_power_down_entry: assert property (
    tk && wb_we_i && wb_sel_i[0] && wb_dat_i[1] && wb_adr_i == 10'h21C |=> power_down_o)
    else $error("power-down not entered");
  a_wake_pin_high: assert property (
    $fell(power_down_o) |-> $past(ext_irq_pin_zero_n_i) || $past(ext_irq_pin_one_n_i))
    else $error("wake before pin high");
  a_reset_clears_all: assert property (disable iff (1'b0)
    rst_i |=> !power_down_o && !irq_req_o && !wb_ack_o)
    else $error("outputs not cleared by reset");
  c_tmr2_taken: cover property (vector_ack_i && irq_vec_o == 3'h5);
  c_top_level: cover property (irq_req_o && irq_lvl_o == 2'h3);
  c_wake: cover property ($fell(power_down_o));
endmodule // flic_checker

bind flic_top flic_checker #(.ADR_W(ADR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin_zero_n_i(ext_irq_pin_zero_n_i),
  .ext_irq_pin_one_n_i(ext_irq_pin_one_n_i), .vector_ack_i(vector_ack_i),
  .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o), .irq_lvl_o(irq_lvl_o),
  .power_down_o(power_down_o)
);

// ---- bench/flic_core_model.sv ----
// core side model: takes vectors and issues returns
`timescale 1ns/100ps
module flic_core_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       irq_req_i,
  input  wire [2:0] irq_vec_i,
  input  wire [1:0] irq_lvl_i,
  input  wire       ret_cmd_i,
  output reg        vector_ack_o,
  output reg        ret_o,
  output reg  [2:0] got_vec_o,
  output reg  [1:0] got_lvl_o,
  output reg  [7:0] n_got_o
);
  wire take = irq_req_i && !vector_ack_o;
  always @(posedge clk_i) begin
    if (rst_i) begin
      vector_ack_o <= 1'b0;
      ret_o        <= 1'b0;
      n_got_o      <= 8'h00;
    end else begin
      vector_ack_o <= take;
      // return never with take
      // a return beside a take would be dropped by the block
      ret_o <= ret_cmd_i && !take;
      if (take) begin
        got_vec_o <= irq_vec_i;
        got_lvl_o <= irq_lvl_i;
        n_got_o   <= n_got_o + 8'h01;
      end
    end
  end
endmodule // flic_core_model

// ---- bench/flic_tb.sv ----
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, p0_n = 1'b1, p1_n = 1'b1;
  logic        t0 = 1'b0, t1 = 1'b0, t2o = 1'b0, t2e = 1'b0, ser = 1'b0, ret_cmd = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0, q;
  wire  [31:0] rdat;
  wire         ack, vack, ret, req, pd;
  wire  [2:0]  vec, gvec;
  wire  [1:0]  lvl, glvl;
  wire  [7:0]  ngot;
  int          n_mismatch = 0, num_checks = 0;
  flic_top #(.ADR_W(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_pin_zero_n_i(p0_n), .ext_irq_pin_one_n_i(p1_n), .first_timer_ovf_i(t0),
    .second_timer_ovf_i(t1), .third_timer_ovf_i(t2o), .third_timer_ext_i(t2e),
    .serial_irq_i(ser), .vector_ack_i(vack), .return_from_interrupt_instr_i(ret),
    .irq_req_o(req), .irq_vec_o(vec), .irq_lvl_o(lvl), .power_down_o(pd));
  flic_core_model core (
    .clk_i(clk_i), .rst_i(rst_i), .irq_req_i(req), .irq_vec_i(vec), .irq_lvl_i(lvl),
    .ret_cmd_i(ret_cmd), .vector_ack_o(vack), .ret_o(ret), .got_vec_o(gvec),
    .got_lvl_o(glvl), .n_got_o(ngot));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("bus ack", 32'h1, {31'h0, ack});
    @(posedge clk_i);
  endtask
  task automatic wait_got(input logic [7:0] was);
    int n;
    n = 0;
    while (ngot === was && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    chk("vector taken", 32'h1, {31'h0, ngot !== was});
  endtask
  task automatic ret_pulse;
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic fire(input int s, input logic v);
    case (s)
      0: p0_n <= !v;
      1: t0 <= v;
      2: p1_n <= !v;
      3: t1 <= v;
      4: ser <= v;
      5: t2o <= v;
      default: t2e <= v;
    endcase
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    wb(10'h2DC, 1'b0, 8'h00);
    chk("upper reset", 32'h0, q);
    wb(10'h2DC, 1'b1, 8'hFF);
    wb(10'h2DC, 1'b0, 8'h00);
    chk("upper bits", 32'h7F, q);
    sel <= 4'hE;
    wb(10'h2DC, 1'b1, 8'h00);
    sel <= 4'hF;
    wb(10'h2DC, 1'b0, 8'h00);
    chk("lane zero off", 32'h7F, q);
    wb(10'h3FC, 1'b1, 8'hFF);
    wb(10'h3FC, 1'b0, 8'h00);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_srcs;
    int s, src;
    logic [1:0] lv;
    logic [7:0] g;
    for (s = 0; s < 7; s++) begin
      src = (s > 5) ? 5 : s;
      lv = s[1:0];
      wb(10'h2DC, 1'b1, {7'h0, lv[1]} << src);
      wb(10'h2E0, 1'b1, {7'h0, lv[0]} << src);
      wb(10'h2A0, 1'b1, 8'h80 | (8'h01 << src));
      g = ngot;
      fire(s, 1'b1);
      @(posedge clk_i);
      if (s == 1 || s == 3 || s > 4) fire(s, 1'b0);
      wait_got(g);
      fire(s, 1'b0);
      chk("vector", src, gvec);
      chk("level", lv, glvl);
      wb(10'h320, 1'b0, 8'h00);
      if (src == 5) chk("tmr2 flag kept", 32'h1, (q >> s) & 32'h1);
      wb(10'h320, 1'b1, 8'h00);
      wb(10'h340, 1'b0, 8'h00);
      chk("in service", 32'h1, {31'h0, q[3:0] != 4'h0});
      ret_pulse;
      wb(10'h340, 1'b0, 8'h00);
      chk("service ended", 32'h0, q & 32'hF);
    end
  endtask
  task automatic t_prio;
    int c;
    logic [7:0] g;
    wb(10'h2A0, 1'b1, 8'h8A);
    for (c = 0; c < 2; c++) begin
      wb(10'h2DC, 1'b1, c ? 8'h00 : 8'h08);
      wb(10'h2E0, 1'b1, c ? 8'h00 : 8'h08);
      g = ngot;
      t0 <= 1'b1;
      t1 <= 1'b1;
      @(posedge clk_i);
      t0 <= 1'b0;
      t1 <= 1'b0;
      wait_got(g);
      chk("first vector", c ? 32'h1 : 32'h3, gvec);
      g = ngot;
      repeat (40) @(posedge clk_i);
      chk("held back", 32'h0, {31'h0, req});
      ret_pulse;
      wait_got(g);
      chk("second vector", c ? 32'h3 : 32'h1, gvec);
      ret_pulse;
    end
  endtask
  task automatic t_edge;
    logic [7:0] g;
    wb(10'h220, 1'b1, 8'h02);
    wb(10'h2DC, 1'b1, 8'h00);
    wb(10'h2E0, 1'b1, 8'h00);
    wb(10'h2A0, 1'b1, 8'h84);
    g = ngot;
    p1_n <= 1'b0;
    @(posedge clk_i);
    p1_n <= 1'b1;
    wait_got(g);
    chk("edge vector", 32'h2, gvec);
    wb(10'h320, 1'b0, 8'h00);
    chk("edge flag taken", 32'h0, q & 32'h4);
    ret_pulse;
    wb(10'h340, 1'b0, 8'h00);
    chk("edge service ended", 32'h0, q & 32'hF);
    wb(10'h220, 1'b1, 8'h00);
  endtask
  task automatic t_pwr;
    int n;
    logic [7:0] g;
    wb(10'h2A0, 1'b1, 8'h81);
    wb(10'h220, 1'b1, 8'h00);
    wb(10'h2DC, 1'b1, 8'h15);
    wb(10'h21C, 1'b1, 8'h02);
    chk("down", 32'h1, {31'h0, pd});
    g = ngot;
    p0_n <= 1'b0;
    repeat (30) @(posedge clk_i);
    p0_n <= 1'b1;
    n = 0;
    while (pd !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("woken", 32'h0, {31'h0, pd});
    wait_got(g);
    chk("wake vector", 32'h0, gvec);
    wb(10'h2DC, 1'b0, 8'h00);
    chk("upper kept", 32'h15, q);
    ret_pulse;
    wb(10'h21C, 1'b1, 8'h02);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset wake", 32'h0, {31'h0, pd});
    wb(10'h2DC, 1'b0, 8'h00);
    chk("upper cleared", 32'h0, q);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_srcs;
    t_prio;
    t_edge;
    t_pwr;
    final_report;
  end
  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    final_report;
  end
endmodule // testbench

// ---- hdl/flic_defs.vh ----
// constants of the four level interrupt controller
`ifndef FLIC_DEFS_VH
`define FLIC_DEFS_VH
// register indices, byte address is four times the index
`define FLIC_IDX_PRIO_UPPER 8'hB7
`define FLIC_IDX_PRIO_LOWER 8'hB8
`define FLIC_IDX_ENABLE     8'hA8
`define FLIC_IDX_FLAGS      8'hC8
`define FLIC_IDX_EXT_CTRL   8'h88
`define FLIC_IDX_POWER      8'h87
`define FLIC_IDX_STATUS     8'hD0
// reset values
`define FLIC_RST_PRIO_UPPER 7'h00
`define FLIC_RST_PRIO_LOWER 6'h00
`define FLIC_RST_ENABLE     7'h00
`define FLIC_RST_EXT_CTRL   2'h0
// source indices, also bit positions in the priority and enable registers
`define FLIC_SRC_EXT0       0
`define FLIC_SRC_TMR0       1
`define FLIC_SRC_EXT1       2
`define FLIC_SRC_TMR1       3
`define FLIC_SRC_SERIAL     4
`define FLIC_SRC_TMR2       5
`define FLIC_SRC_NUM        6
`define FLIC_BIT_ARRAY_PRIO 6
`define FLIC_BIT_GLOBAL_EN  7
// flag register layout
`define FLIC_FLG_EXT0       0
`define FLIC_FLG_TMR0       1
`define FLIC_FLG_EXT1       2
`define FLIC_FLG_TMR1       3
`define FLIC_FLG_SERIAL     4
`define FLIC_FLG_TMR2_OVF   5
`define FLIC_FLG_TMR2_EXT   6
// external control and power register fields
`define FLIC_BIT_EDGE0      0
`define FLIC_BIT_EDGE1      1
`define FLIC_BIT_PWR_DOWN   1
// machine cycle phases, twelve clocks per cycle
`define FLIC_PH_SET_TMR2    4'h3
`define FLIC_PH_POLL        4'h9
`define FLIC_PH_DECIDE      4'hB
`define FLIC_PH_LAST        4'hB
`endif

// ---- hdl/flic_top.v ----
// four level interrupt controller with classic wishbone register access
// Functional notes
// R01 - six vectors: two pins, three timers, serial
// R02 - third timer request is overflow OR event
// R03 - third timer flags survive vectoring, software clears
// R04 - timers one, two: state_five_phase_two, polled next
// R05 - timer three flag: state_two_phase_two, polled same cycle
// R06 - level is upper bit MSB, lower bit LSB
// R07 - upper priority bit layout, bit seven reserved
// R08 - power-down left by reset or pin interrupt
// R09 - level pin low then high completes wake
// R10 - return instruction ends service, core resumes after
// R11 - waker holds signal until oscillator stable; the code drops power_down_o on the wake with no settling wait
// R12 - higher level preempts, ties by fixed order
`timescale 1ns/100ps
`include "flic_defs.vh"

module flic_top #(
  parameter ADR_W = 10
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [ADR_W-1:0] wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  input  wire             ext_irq_pin_zero_n_i,
  input  wire             ext_irq_pin_one_n_i,
  input  wire             first_timer_ovf_i,
  input  wire             second_timer_ovf_i,
  input  wire             third_timer_ovf_i,
  input  wire             third_timer_ext_i,
  input  wire             serial_irq_i,
  input  wire             vector_ack_i,
  input  wire             return_from_interrupt_instr_i,
  output reg              irq_req_o,
  output reg  [2:0]       irq_vec_o,
  output reg  [1:0]       irq_lvl_o,
  output reg              power_down_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // only byte lane zero carries register data, the other lanes are ignored
  wire       bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0] bus_idx   = wb_adr_i[9:2];
  wire [7:0] wr_byte   = wb_dat_i[7:0];
  wire       wr_pupper = bus_wr & (bus_idx == `FLIC_IDX_PRIO_UPPER);
  wire       wr_plower = bus_wr & (bus_idx == `FLIC_IDX_PRIO_LOWER);
  wire       wr_enable = bus_wr & (bus_idx == `FLIC_IDX_ENABLE);
  wire       wr_flags  = bus_wr & (bus_idx == `FLIC_IDX_FLAGS);
  wire       wr_extc   = bus_wr & (bus_idx == `FLIC_IDX_EXT_CTRL);
  wire       wr_power  = bus_wr & (bus_idx == `FLIC_IDX_POWER);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [3:0] phase_q;
  reg [6:0] prio_upper_q;
  reg [5:0] prio_lower_q;
  reg [6:0] enable_q;
  reg [1:0] ext_ctrl_q;
  reg       pin0_q;
  reg       pin1_q;
  reg       ie0_q;
  reg       ie1_q;
  reg       tmr0_ovf_q;
  reg       tmr1_ovf_q;
  reg       tmr2_ovf_q;
  reg       tmr2_ext_q;
  reg       ev0_q;
  reg       ev1_q;
  reg       ev2_q;
  reg       evx_q;
  reg [5:0] poll_q;
  reg [3:0] in_service_q;
  reg [1:0] wake_low_q;
  reg [1:0] wake_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // phase strobes stay quiet while the oscillator is stopped; a frozen phase
  // would otherwise poll or grant on every clock of power-down
  wire osc_run   = ~power_down_o;
  wire at_set2   = osc_run & (phase_q == `FLIC_PH_SET_TMR2);
  wire at_poll   = osc_run & (phase_q == `FLIC_PH_POLL);
  wire at_decide = osc_run & (phase_q == `FLIC_PH_DECIDE);
  // the stored enable drops the unused bit, so the global enable sits at six
  wire glb_en    = enable_q[6];
  wire fall0     = pin0_q & ~ext_irq_pin_zero_n_i;
  wire fall1     = pin1_q & ~ext_irq_pin_one_n_i;
  // a take counts only while a request is shown
  wire take      = vector_ack_i & irq_req_o;
  wire ack_x0    = take & (irq_vec_o == `FLIC_SRC_EXT0);
  wire ack_t0    = take & (irq_vec_o == `FLIC_SRC_TMR0);
  wire ack_x1    = take & (irq_vec_o == `FLIC_SRC_EXT1);
  wire ack_t1    = take & (irq_vec_o == `FLIC_SRC_TMR1);

  // a zero written to a flag bit clears it, a one leaves it alone
  wire clr_ie0   = wr_flags & ~wr_byte[`FLIC_FLG_EXT0];
  wire clr_ie1   = wr_flags & ~wr_byte[`FLIC_FLG_EXT1];
  wire clr_ovf0  = wr_flags & ~wr_byte[`FLIC_FLG_TMR0];
  wire clr_ovf1  = wr_flags & ~wr_byte[`FLIC_FLG_TMR1];
  wire clr_ovf2  = wr_flags & ~wr_byte[`FLIC_FLG_TMR2_OVF];
  wire clr_ext2  = wr_flags & ~wr_byte[`FLIC_FLG_TMR2_EXT];

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencer, stops while the oscillator is down
  always @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 4'h0;
    end else if (!power_down_o) begin
      phase_q <= (phase_q == `FLIC_PH_LAST) ? 4'h0 : phase_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      prio_upper_q <= `FLIC_RST_PRIO_UPPER;
      prio_lower_q <= `FLIC_RST_PRIO_LOWER;
      enable_q     <= `FLIC_RST_ENABLE;
      ext_ctrl_q   <= `FLIC_RST_EXT_CTRL;
    end else begin
      // the counter array bit is dropped from the enable; the upper priority stores it and reads it back, no level uses it
      // R07 upper bit layout
      if (wr_pupper) begin
        prio_upper_q <= wr_byte[6:0];
      end
      if (wr_plower) begin
        prio_lower_q <= wr_byte[5:0];
      end
      if (wr_enable) begin
        enable_q <= {wr_byte[7], wr_byte[5:0]};
      end
      if (wr_extc) begin
        ext_ctrl_q <= wr_byte[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source flags; a hardware set always beats a software clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
      ie0_q  <= 1'b0;
      ie1_q  <= 1'b0;
      tmr0_ovf_q <= 1'b0;
      tmr1_ovf_q <= 1'b0;
      tmr2_ovf_q <= 1'b0;
      tmr2_ext_q <= 1'b0;
      ev0_q  <= 1'b0;
      ev1_q  <= 1'b0;
      ev2_q  <= 1'b0;
      evx_q  <= 1'b0;
    end else begin
      pin0_q <= ext_irq_pin_zero_n_i;
      pin1_q <= ext_irq_pin_one_n_i;
      // overflow events wait for their set point in the cycle
      ev0_q  <= (ev0_q | first_timer_ovf_i) & ~at_poll;
      ev1_q  <= (ev1_q | second_timer_ovf_i) & ~at_poll;
      ev2_q  <= (ev2_q | third_timer_ovf_i) & ~at_set2;
      evx_q  <= (evx_q | third_timer_ext_i) & ~at_set2;
      // edge flags clear on vectoring, level mode keeps none
      ie0_q  <= (ext_ctrl_q[`FLIC_BIT_EDGE0] & fall0) |
                (ie0_q & ext_ctrl_q[`FLIC_BIT_EDGE0] & ~ack_x0 &
                 ~clr_ie0);
      ie1_q  <= (ext_ctrl_q[`FLIC_BIT_EDGE1] & fall1) |
                (ie1_q & ext_ctrl_q[`FLIC_BIT_EDGE1] & ~ack_x1 &
                 ~clr_ie1);
      // R04 set at state five phase two
      tmr0_ovf_q <= ((ev0_q | first_timer_ovf_i) & at_poll) |
                    (tmr0_ovf_q & ~ack_t0 & ~clr_ovf0);
      tmr1_ovf_q <= ((ev1_q | second_timer_ovf_i) & at_poll) |
                    (tmr1_ovf_q & ~ack_t1 & ~clr_ovf1);
      // R05 set at state two phase two
      tmr2_ovf_q <= ((ev2_q | third_timer_ovf_i) & at_set2) |
                    (tmr2_ovf_q & ~clr_ovf2);
      // R03 no clear on vectoring
      tmr2_ext_q <= ((evx_q | third_timer_ext_i) & at_set2) |
                    (tmr2_ext_q & ~clr_ext2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // raw requests and priority levels per source
  wire [5:0] src_raw;
  wire [1:0] src_lvl [0:5];
  // R01 six sources
  assign src_raw[`FLIC_SRC_EXT0]   = (ext_ctrl_q[`FLIC_BIT_EDGE0] ? ie0_q : ~pin0_q) |
                                     wake_pend_q[0];
  assign src_raw[`FLIC_SRC_TMR0]   = tmr0_ovf_q;
  assign src_raw[`FLIC_SRC_EXT1]   = (ext_ctrl_q[`FLIC_BIT_EDGE1] ? ie1_q : ~pin1_q) |
                                     wake_pend_q[1];
  assign src_raw[`FLIC_SRC_TMR1]   = tmr1_ovf_q;
  assign src_raw[`FLIC_SRC_SERIAL] = serial_irq_i;
  // R02 overflow OR event
  assign src_raw[`FLIC_SRC_TMR2]   = tmr2_ovf_q | tmr2_ext_q;

  genvar g;
  generate
    for (g = 0; g < `FLIC_SRC_NUM; g = g + 1) begin : g_lvl
      // R06 upper as MSB
      assign src_lvl[g] = {prio_upper_q[g], prio_lower_q[g]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // polling: flags set at state five phase two are seen one cycle later;
  // a flag taken right at the poll point is caught once more, but the level
  // it now holds in service keeps it from being granted again
  always @(posedge clk_i) begin
    if (rst_i) begin
      poll_q <= 6'h00;
    end else if (at_poll) begin
      // R04 R05 one poll point
      poll_q <= src_raw & enable_q[5:0] & {6{glb_en}};
    end else if (vector_ack_i & irq_req_o) begin
      poll_q[irq_vec_o] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and in-service tracking
  reg       best_fnd;
  reg [2:0] best_src;
  reg [1:0] best_lvl;
  reg       svc_any;
  reg [1:0] svc_top;
  integer   i;

  always @* begin
    best_fnd = 1'b0;
    best_src = 3'h0;
    best_lvl = 2'h0;
    svc_any  = |in_service_q;
    svc_top  = 2'h0;
    // the highest set in-service bit is the level now being served
    for (i = 0; i < 4; i = i + 1) begin
      if (in_service_q[i]) begin
        svc_top = i[1:0];
      end
    end
    // R12 highest level, ties to lowest index
    for (i = 0; i < `FLIC_SRC_NUM; i = i + 1) begin
      if (poll_q[i] && (!best_fnd || src_lvl[i] > best_lvl)) begin
        best_fnd = 1'b1;
        best_src = i[2:0];
        best_lvl = src_lvl[i];
      end
    end
  end

  // R12 preempt only when higher
  wire grant_ok = best_fnd & (!svc_any | (best_lvl > svc_top));

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o    <= 1'b0;
      irq_vec_o    <= 3'h0;
      irq_lvl_o    <= 2'h0;
      in_service_q <= 4'h0;
    end else begin
      if (vector_ack_i & irq_req_o) begin
        irq_req_o                <= 1'b0;
        in_service_q[irq_lvl_o]  <= 1'b1;
      end else if (at_decide) begin
        irq_req_o <= grant_ok;
        irq_vec_o <= best_src;
        irq_lvl_o <= best_lvl;
      end
      // a return in the cycle of a take is dropped; the core never sends both
      // R10 return ends top service
      if (return_from_interrupt_instr_i & svc_any & ~(vector_ack_i & irq_req_o)) begin
        in_service_q[svc_top] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down; reset clears it with every other register except the pin samples, which reset high
  // only a level-mode pin can wake the block; an edge-mode pin is ignored here
  wire wake_arm0 = glb_en & enable_q[`FLIC_SRC_EXT0] & ~ext_ctrl_q[`FLIC_BIT_EDGE0];
  wire wake_arm1 = glb_en & enable_q[`FLIC_SRC_EXT1] & ~ext_ctrl_q[`FLIC_BIT_EDGE1];
  wire wake_done = power_down_o & ((wake_low_q[0] & pin0_q) | (wake_low_q[1] & pin1_q));

  always @(posedge clk_i) begin
    // R08 reset exit
    if (rst_i) begin
      power_down_o <= 1'b0;
      wake_low_q   <= 2'h0;
      wake_pend_q  <= 2'h0;
    end else begin
      // R08 pin exit, only the power-down bit changes
      if (wake_done) begin
        power_down_o <= 1'b0;
      end else if (wr_power & ~power_down_o) begin
        power_down_o <= wr_byte[`FLIC_BIT_PWR_DOWN];
      end
      // R09 pin low restarts, high completes
      wake_low_q[0] <= power_down_o & wake_arm0 & (wake_low_q[0] | ~pin0_q) & ~wake_done;
      wake_low_q[1] <= power_down_o & wake_arm1 & (wake_low_q[1] | ~pin1_q) & ~wake_done;
      // the level is gone by now, so the request is held until vectored
      wake_pend_q[0] <= (wake_done & wake_low_q[0]) | (wake_pend_q[0] & ~ack_x0);
      wake_pend_q[1] <= (wake_done & wake_low_q[1]) | (wake_pend_q[1] & ~ack_x1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer, one wait state, unmapped reads return zero
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (bus_idx)
      `FLIC_IDX_PRIO_UPPER: rd_byte = {1'b0, prio_upper_q};
      `FLIC_IDX_PRIO_LOWER: rd_byte = {2'b00, prio_lower_q};
      `FLIC_IDX_ENABLE:     rd_byte = {enable_q[6], 1'b0, enable_q[5:0]};
      // the serial request is shown live, it keeps no flag of its own
      `FLIC_IDX_FLAGS:      rd_byte = {1'b0, tmr2_ext_q, tmr2_ovf_q, serial_irq_i,
                                       tmr1_ovf_q, ie1_q, tmr0_ovf_q, ie0_q};
      `FLIC_IDX_EXT_CTRL:   rd_byte = {6'h00, ext_ctrl_q};
      `FLIC_IDX_POWER:      rd_byte = {6'h00, power_down_o, 1'b0};
      `FLIC_IDX_STATUS:     rd_byte = {irq_req_o, irq_lvl_o, 1'b0, in_service_q};
      default:              rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule // flic_top
